/* File: aux_alert_channel.v */
// hysteresis alert state for one auxiliary channel
`timescale 1ns/1ns
`include "aux_thr_defs.vh"
module aux_alert_channel (
    input wire clk_i,                      // system clock
    input wire rst_i,                      // synchronous reset, active high
    input wire ce_i,                       // clock enable
    input wire sample_i,                   // new result for this channel
    input wire ref_abs_i,                  // 1 absolute, 0 ratiometric
    input wire [`THR_W-1:0] result_i,      // measurement result
    input wire [`THR_W-1:0] r_low_set_i,   // ratiometric low set level
    input wire [`THR_W-1:0] r_low_clr_i,   // ratiometric low clear level
    input wire [`THR_W-1:0] a_high_set_i,  // absolute high set level
    input wire [`THR_W-1:0] a_high_clr_i,  // absolute high clear level
    input wire [`THR_W-1:0] a_low_set_i,   // absolute low set level
    input wire [`THR_W-1:0] a_low_clr_i,   // absolute low clear level
    output reg low_alert_o,                // low alert
    output reg high_alert_o                // high alert
);
    reg [`THR_W-1:0] low_set;
    reg [`THR_W-1:0] low_clr;
    reg low_assert;
    reg low_release;
    reg high_assert;
    reg high_release;

    always @* begin
        low_set = ref_abs_i ? a_low_set_i : r_low_set_i;
        low_clr = ref_abs_i ? a_low_clr_i : r_low_clr_i;
        // a zero set level can never be undercut
        low_assert = (low_set != `THR_OFF_LOW) && (result_i < low_set);
        low_release = (result_i >= low_clr);
        // there is no ratiometric high pair, so the high check runs only for absolute channels
        high_assert = ref_abs_i && (a_high_set_i != `THR_OFF_HIGH)
            && (result_i > a_high_set_i);
        high_release = !ref_abs_i || (result_i <= a_high_clr_i);
    end

    always @(posedge clk_i) begin
        if (rst_i) begin
            low_alert_o <= 1'b0;
            high_alert_o <= 1'b0;
        end else if (ce_i && sample_i) begin
            // assert wins when both hold, which only happens with bad levels
            if (low_assert)
                low_alert_o <= 1'b1;
            else if (low_release)
                low_alert_o <= 1'b0;
            if (high_assert)
                high_alert_o <= 1'b1;
            else if (high_release)
                high_alert_o <= 1'b0;
        end
    end
endmodule

/* File: aux_alert_threshold_regs.v */
// auxiliary alert threshold registers with wishbone slave and per-channel alert logic
// ----------------------------------------------------------------------------
// Functional notes
// - ratiometric result strictly below the ratiometric low set level raises the low alert.
// - ratiometric result at or above the ratiometric low clear level drops the low alert.
// - the ratiometric pair is used only for channels whose reference select is 0.
// - the absolute registers are used only for channels whose reference select is 1.
// - absolute result strictly above the absolute high set level raises the high alert.
// - absolute result at or below the absolute high clear level drops the high alert.
// - absolute result at or above the absolute low clear level drops the low alert.
// - absolute result strictly below the absolute low set level raises the low alert.
// - a high set level of all ones never triggers, switching high checks off.
// - a low set level of zero never triggers, switching low checks off.
// - each threshold sits in bits 15:2 of its word, bits 1:0 unused and read zero.
// - every threshold register is read/write and reads back the last value written.
// ----------------------------------------------------------------------------
//
// Local design decision: the Wishbone register port.
`timescale 1ns/1ns
`include "aux_thr_defs.vh"
module aux_alert_threshold_regs (
    input wire clk_i,                   // system clock, 100 MHz
    input wire rst_i,                   // synchronous reset, active high
    input wire ce_i,                    // clock enable, freezes all state when low
    input wire wb_cyc_i,                // wishbone cycle
    input wire wb_stb_i,                // wishbone strobe
    input wire wb_we_i,                 // wishbone write enable
    input wire [9:0] wb_adr_i,          // wishbone byte address
    input wire [3:0] wb_sel_i,          // wishbone byte selects
    input wire [31:0] wb_dat_i,         // wishbone write data
    output reg [31:0] wb_dat_o,         // wishbone read data
    output reg wb_ack_o,                // wishbone acknowledge
    output reg wb_err_o,                // wishbone error, unmapped address
    input wire meas_valid_i,            // one-cycle pulse: new result present
    input wire [1:0] meas_chan_i,       // auxiliary channel of the result
    input wire [`THR_W-1:0] meas_data_i, // 14-bit result
    output reg [`NUM_AUX-1:0] aux_low_alert_o, // low alert per channel
    output reg [`NUM_AUX-1:0] aux_high_alert_o // high alert per channel
);
    // ------------------------------------------------------------------------
    // register storage
    // ------------------------------------------------------------------------
    reg [`THR_W-1:0] ratio_low_clear_level_q;
    reg [`THR_W-1:0] ratio_low_set_level_q;
    reg [`THR_W-1:0] abs_high_clear_level_q;
    reg [`THR_W-1:0] abs_high_set_level_q;
    reg [`THR_W-1:0] abs_low_clear_level_q;
    reg [`THR_W-1:0] abs_low_set_level_q;
    reg [`NUM_AUX-1:0] aux_reference_select_q;

    wire [`THR_W-1:0] rst_rlc = `RST_RATIO_LOW_CLR;
    wire [`THR_W-1:0] rst_rls = `RST_RATIO_LOW_SET;
    wire [`THR_W-1:0] rst_ahc = `RST_ABS_HIGH_CLR;
    wire [`THR_W-1:0] rst_ahs = `RST_ABS_HIGH_SET;
    wire [`THR_W-1:0] rst_alc = `RST_ABS_LOW_CLR;
    wire [`THR_W-1:0] rst_als = `RST_ABS_LOW_SET;
    wire [31:0] rst_ctl = `RST_CTRL;

    // ------------------------------------------------------------------------
    // bus decode
    // ------------------------------------------------------------------------
    wire req = wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;
    wire [7:0] idx = wb_adr_i[9:2];
    reg hit;
    reg [31:0] rd_d;
    wire [15:0] wr_half = {wb_sel_i[1] ? wb_dat_i[15:8] : 8'h00,
        wb_sel_i[0] ? wb_dat_i[7:0] : 8'h00};
    wire wr_en = req && wb_we_i && hit;

    // threshold word with the two unused low bits forced to zero
    function [31:0] thr_word;
        input [`THR_W-1:0] lvl;
        begin
            thr_word = {16'h0000, lvl, 2'b00};
        end
    endfunction

    // partial byte write of a threshold field keeps the unselected lane
    function [`THR_W-1:0] merge_thr;
        input [`THR_W-1:0] old;
        input [15:0] wd;
        input [1:0] sel;
        reg [15:0] cur;
        begin
            cur = {old, 2'b00};
            if (sel[0])
                cur[7:0] = wd[7:0];
            if (sel[1])
                cur[15:8] = wd[15:8];
            merge_thr = cur[`THR_MSB:`THR_LSB];
        end
    endfunction

    always @* begin
        hit = 1'b1;
        rd_d = 32'h0000_0000;
        case (idx)
            `IDX_RATIO_LOW_CLR: rd_d = thr_word(ratio_low_clear_level_q);
            `IDX_RATIO_LOW_SET: rd_d = thr_word(ratio_low_set_level_q);
            `IDX_ABS_HIGH_CLR: rd_d = thr_word(abs_high_clear_level_q);
            `IDX_ABS_HIGH_SET: rd_d = thr_word(abs_high_set_level_q);
            `IDX_ABS_LOW_CLR: rd_d = thr_word(abs_low_clear_level_q);
            `IDX_ABS_LOW_SET: rd_d = thr_word(abs_low_set_level_q);
            `IDX_CTRL: rd_d = {28'h0000000, aux_reference_select_q};
            `IDX_STATUS: rd_d = {24'h000000, aux_high_alert_o, aux_low_alert_o};
            default: hit = 1'b0;
        endcase
    end

    // ------------------------------------------------------------------------
    // bus answer: one cycle after the request, dropped the cycle after
    // ------------------------------------------------------------------------
    always @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
            wb_err_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end else if (ce_i) begin
            wb_ack_o <= req && hit;
            wb_err_o <= req && !hit;
            if (req && hit && !wb_we_i)
                wb_dat_o <= rd_d;
            else
                wb_dat_o <= 32'h0000_0000;
        end
    end

    // ------------------------------------------------------------------------
    // write strobes
    // ------------------------------------------------------------------------
    // address decode shared by all write strobes
    wire at_rlc = (idx == `IDX_RATIO_LOW_CLR);
    wire at_rls = (idx == `IDX_RATIO_LOW_SET);
    wire at_ahc = (idx == `IDX_ABS_HIGH_CLR);
    wire at_ahs = (idx == `IDX_ABS_HIGH_SET);
    wire at_alc = (idx == `IDX_ABS_LOW_CLR);
    wire at_als = (idx == `IDX_ABS_LOW_SET);
    wire at_ctl = (idx == `IDX_CTRL);

    // one strobe per register so each store stands alone
    wire wr_rlc = wr_en && at_rlc;
    wire wr_rls = wr_en && at_rls;
    wire wr_ahc = wr_en && at_ahc;
    wire wr_ahs = wr_en && at_ahs;
    wire wr_alc = wr_en && at_alc;
    wire wr_als = wr_en && at_als;
    // ctrl lives in one byte lane; the other lanes are ignored
    wire wr_ctl = wr_en && at_ctl && wb_sel_i[0];

    // ------------------------------------------------------------------------
    // register stores
    // ------------------------------------------------------------------------
    // writes take effect at the edge that raises ack
    always @(posedge clk_i) begin
        if (rst_i)
            ratio_low_clear_level_q <= rst_rlc;
        else if (ce_i && wr_rlc)
            ratio_low_clear_level_q <=
                merge_thr(ratio_low_clear_level_q, wr_half, wb_sel_i[1:0]);
    end

    always @(posedge clk_i) begin
        if (rst_i)
            ratio_low_set_level_q <= rst_rls;
        else if (ce_i && wr_rls)
            ratio_low_set_level_q <=
                merge_thr(ratio_low_set_level_q, wr_half, wb_sel_i[1:0]);
    end

    always @(posedge clk_i) begin
        if (rst_i)
            abs_high_clear_level_q <= rst_ahc;
        else if (ce_i && wr_ahc)
            abs_high_clear_level_q <=
                merge_thr(abs_high_clear_level_q, wr_half, wb_sel_i[1:0]);
    end

    always @(posedge clk_i) begin
        if (rst_i)
            abs_high_set_level_q <= rst_ahs;
        else if (ce_i && wr_ahs)
            abs_high_set_level_q <=
                merge_thr(abs_high_set_level_q, wr_half, wb_sel_i[1:0]);
    end

    always @(posedge clk_i) begin
        if (rst_i)
            abs_low_clear_level_q <= rst_alc;
        else if (ce_i && wr_alc)
            abs_low_clear_level_q <=
                merge_thr(abs_low_clear_level_q, wr_half, wb_sel_i[1:0]);
    end

    always @(posedge clk_i) begin
        if (rst_i)
            abs_low_set_level_q <= rst_als;
        else if (ce_i && wr_als)
            abs_low_set_level_q <=
                merge_thr(abs_low_set_level_q, wr_half, wb_sel_i[1:0]);
    end

    always @(posedge clk_i) begin
        if (rst_i)
            aux_reference_select_q <= rst_ctl[`NUM_AUX-1:0];
        else if (ce_i && wr_ctl)
            aux_reference_select_q <= wb_dat_i[`NUM_AUX-1:0];
    end

    // ------------------------------------------------------------------------
    // per-channel alert state; outputs pass through one more flop stage after the channel flops
    // ------------------------------------------------------------------------
    wire [`NUM_AUX-1:0] low_w;
    wire [`NUM_AUX-1:0] high_w;
    wire [`NUM_AUX-1:0] chan_sample;

    // only the addressed channel sees the result strobe
    assign chan_sample[0] = meas_valid_i && (meas_chan_i == 2'h0);
    assign chan_sample[1] = meas_valid_i && (meas_chan_i == 2'h1);
    assign chan_sample[2] = meas_valid_i && (meas_chan_i == 2'h2);
    assign chan_sample[3] = meas_valid_i && (meas_chan_i == 2'h3);

    aux_alert_channel u_chan0 (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .ce_i(ce_i),
        .sample_i(chan_sample[0]),
        .ref_abs_i(aux_reference_select_q[0]),
        .result_i(meas_data_i),
        .r_low_set_i(ratio_low_set_level_q),
        .r_low_clr_i(ratio_low_clear_level_q),
        .a_high_set_i(abs_high_set_level_q),
        .a_high_clr_i(abs_high_clear_level_q),
        .a_low_set_i(abs_low_set_level_q),
        .a_low_clr_i(abs_low_clear_level_q),
        .low_alert_o(low_w[0]),
        .high_alert_o(high_w[0])
    );

    aux_alert_channel u_chan1 (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .ce_i(ce_i),
        .sample_i(chan_sample[1]),
        .ref_abs_i(aux_reference_select_q[1]),
        .result_i(meas_data_i),
        .r_low_set_i(ratio_low_set_level_q),
        .r_low_clr_i(ratio_low_clear_level_q),
        .a_high_set_i(abs_high_set_level_q),
        .a_high_clr_i(abs_high_clear_level_q),
        .a_low_set_i(abs_low_set_level_q),
        .a_low_clr_i(abs_low_clear_level_q),
        .low_alert_o(low_w[1]),
        .high_alert_o(high_w[1])
    );

    aux_alert_channel u_chan2 (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .ce_i(ce_i),
        .sample_i(chan_sample[2]),
        .ref_abs_i(aux_reference_select_q[2]),
        .result_i(meas_data_i),
        .r_low_set_i(ratio_low_set_level_q),
        .r_low_clr_i(ratio_low_clear_level_q),
        .a_high_set_i(abs_high_set_level_q),
        .a_high_clr_i(abs_high_clear_level_q),
        .a_low_set_i(abs_low_set_level_q),
        .a_low_clr_i(abs_low_clear_level_q),
        .low_alert_o(low_w[2]),
        .high_alert_o(high_w[2])
    );

    aux_alert_channel u_chan3 (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .ce_i(ce_i),
        .sample_i(chan_sample[3]),
        .ref_abs_i(aux_reference_select_q[3]),
        .result_i(meas_data_i),
        .r_low_set_i(ratio_low_set_level_q),
        .r_low_clr_i(ratio_low_clear_level_q),
        .a_high_set_i(abs_high_set_level_q),
        .a_high_clr_i(abs_high_clear_level_q),
        .a_low_set_i(abs_low_set_level_q),
        .a_low_clr_i(abs_low_clear_level_q),
        .low_alert_o(low_w[3]),
        .high_alert_o(high_w[3])
    );

    // ------------------------------------------------------------------------
    // alert outputs
    // ------------------------------------------------------------------------
    // extra stage keeps every top output on a flop of this module
    always @(posedge clk_i) begin
        if (rst_i)
            aux_low_alert_o <= {`NUM_AUX{1'b0}};
        else if (ce_i)
            aux_low_alert_o <= low_w;
    end

    always @(posedge clk_i) begin
        if (rst_i)
            aux_high_alert_o <= {`NUM_AUX{1'b0}};
        else if (ce_i)
            aux_high_alert_o <= high_w;
    end
endmodule

/* File: aux_alert_threshold_regs_assertions.sv */
// concurrent checks on the auxiliary alert threshold block
`timescale 1ns/1ns
`include "aux_thr_defs.vh"
module aux_alert_threshold_regs_assertions (
    input wire clk_i, // clock
    input wire rst_i, // reset
    input wire ce_i, // enable
    input wire wb_cyc_i, // cycle
    input wire wb_stb_i, // strobe
    input wire wb_we_i, // write
    input wire [9:0] wb_adr_i, // address
    input wire [31:0] wb_dat_o, // read data
    input wire wb_ack_o, // ack
    input wire wb_err_o, // error
    input wire meas_valid_i, // result strobe
    input wire [1:0] meas_chan_i, // channel
    input wire [`NUM_AUX-1:0] aux_low_alert_o, // low alerts
    input wire [`NUM_AUX-1:0] aux_high_alert_o // high alerts
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    wire [7:0] idx = wb_adr_i[9:2];
    wire thr = idx >= `IDX_RATIO_LOW_CLR && idx <= `IDX_ABS_LOW_SET;
    wire mapped = thr || idx == `IDX_CTRL || idx == `IDX_STATUS;
    reg [3:0] hit1_q, hit2_q;
    // alerts trail their result by two edges
    always @(posedge clk_i) begin
        if (rst_i) begin
            hit1_q <= 4'h0;
            hit2_q <= 4'h0;
        end else if (ce_i) begin
            hit1_q <= meas_valid_i ? (4'h1 << meas_chan_i) : 4'h0;
            hit2_q <= hit1_q;
        end
    end
    sequence s_req;
        wb_cyc_i && wb_stb_i && ce_i && !wb_ack_o && !wb_err_o;
    endsequence
    property p_map_ack; s_req ##0 mapped |=> wb_ack_o && !wb_err_o; endproperty
    property p_err; s_req ##0 !mapped |=> wb_err_o && !wb_ack_o; endproperty
    property p_one; (wb_ack_o || wb_err_o) && ce_i |=> !wb_ack_o && !wb_err_o; endproperty
    property p_idle; !wb_ack_o |-> wb_dat_o == 32'h0; endproperty
    property p_pad; s_req ##0 thr && !wb_we_i |=> wb_dat_o[1:0] == 2'h0; endproperty
    property p_wr_zero; s_req ##0 wb_we_i |=> wb_dat_o == 32'h0; endproperty
    property p_low_quiet;
        ((aux_low_alert_o ^ $past(aux_low_alert_o)) & ~hit2_q) == 4'h0;
    endproperty
    property p_high_quiet;
        ((aux_high_alert_o ^ $past(aux_high_alert_o)) & ~hit2_q) == 4'h0;
    endproperty
    a_map_ack: assert property (p_map_ack) else $error("request not acked");
    a_err: assert property (p_err) else $error("unmapped request not refused");
    a_one: assert property (p_one) else $error("answer longer than one cycle");
    a_idle: assert property (p_idle) else $error("read data outside ack");
    a_pad: assert property (p_pad) else $error("unused bits not zero");
    a_wr_zero: assert property (p_wr_zero) else $error("write returned data");
    a_low_quiet: assert property (p_low_quiet) else $error("low alert moved");
    a_high_quiet: assert property (p_high_quiet) else $error("high alert moved");
    property p_freeze;
        !ce_i |=> $stable(aux_low_alert_o) && $stable(aux_high_alert_o) && $stable(wb_ack_o);
    endproperty
    a_freeze: assert property (p_freeze) else $error("state moved while disabled");
endmodule
bind aux_alert_threshold_regs aux_alert_threshold_regs_assertions chk (
    .clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .wb_err_o(wb_err_o), .meas_valid_i(meas_valid_i), .meas_chan_i(meas_chan_i),
    .aux_low_alert_o(aux_low_alert_o), .aux_high_alert_o(aux_high_alert_o));

/* File: aux_alert_threshold_regs_tb_top.sv */
// self-checking bench for the auxiliary alert threshold block
`timescale 1ns/1ns
`include "aux_thr_defs.vh"
module aux_alert_threshold_regs_tb_top;
    reg clk_i, rst_i, ce_i, wb_cyc_i, wb_stb_i, wb_we_i, meas_valid_i, e;
    reg [9:0] wb_adr_i;
    reg [3:0] wb_sel_i, abs_q, lo_q, hi_q;
    reg [31:0] wb_dat_i, q;
    reg [1:0] meas_chan_i;
    reg [13:0] meas_data_i, r;
    wire [31:0] wb_dat_o;
    wire wb_ack_o, wb_err_o;
    wire [3:0] aux_low_alert_o, aux_high_alert_o;
    reg [15:0] m [0:5];
    integer error_cnt = 0, checks_done = 0, i, k, t, j;
    aux_alert_threshold_regs dut (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i),
        .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
        .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
        .wb_err_o(wb_err_o), .meas_valid_i(meas_valid_i), .meas_chan_i(meas_chan_i),
        .meas_data_i(meas_data_i), .aux_low_alert_o(aux_low_alert_o),
        .aux_high_alert_o(aux_high_alert_o));
    initial begin
        clk_i = 1'b0;
        forever #5 clk_i = ~clk_i;
    end
    task chk_word(input string n, input [31:0] x, input [31:0] g);
        checks_done = checks_done + 1;
        if (g !== x) begin
            error_cnt = error_cnt + 1;
            $display("unexpected %0s: expected %h seen %h", n, x, g);
        end
    endtask
    task chk_alert(input string n, input [3:0] x, input [3:0] g);
        chk_word(n, {28'h0, x}, {28'h0, g});
    endtask
    // no local limit: only the watchdog ends a wait for the answer
    task wb_op(input w, input [9:0] a, input [31:0] d, input [3:0] s);
        begin
            wb_cyc_i <= 1'b1;
            wb_stb_i <= 1'b1;
            wb_we_i <= w;
            wb_adr_i <= a;
            wb_dat_i <= d;
            wb_sel_i <= s;
            do begin
                @(posedge clk_i);
            end while (wb_ack_o !== 1'b1 && wb_err_o !== 1'b1);
            q = wb_dat_o;
            e = wb_err_o;
            wb_cyc_i <= 1'b0;
            wb_stb_i <= 1'b0;
            @(posedge clk_i);
        end
    endtask
    task wr(input integer x, input [31:0] d, input [3:0] s);
        wb_op(1'b1, {8'h32 + x[7:0], 2'b00}, d, s);
        if (s[0]) m[x][7:0] = d[7:0];
        if (s[1]) m[x][15:8] = d[15:8];
        m[x][1:0] = 2'h0;
    endtask
    // hysteresis model: set wins over clear, in-between keeps state
    function [1:0] next_alert(input [1:0] o, input ab, input [13:0] v);
        if (!ab) next_alert = {1'b0, v < m[1][15:2] ? 1'b1 : v >= m[0][15:2] ? 1'b0 : o[0]};
        else next_alert = {v > m[3][15:2] ? 1'b1 : v <= m[2][15:2] ? 1'b0 : o[1],
            v < m[5][15:2] ? 1'b1 : v >= m[4][15:2] ? 1'b0 : o[0]};
    endfunction
    task meas(input [1:0] c, input [13:0] v);
        {hi_q[c], lo_q[c]} = next_alert({hi_q[c], lo_q[c]}, abs_q[c], v);
        meas_valid_i <= 1'b1;
        meas_chan_i <= c;
        meas_data_i <= v;
        @(posedge clk_i);
        meas_valid_i <= 1'b0;
        repeat (2) @(posedge clk_i);
        chk_alert("low alert", lo_q, aux_low_alert_o);
        chk_alert("high alert", hi_q, aux_high_alert_o);
        wb_op(1'b0, 10'h104, 32'h0, 4'hf);
        chk_word("alert status", {24'h0, hi_q, lo_q}, q);
    endtask
    // a result offered while the clock enable is low must leave every alert alone
    task hold_meas(input [1:0] c, input [13:0] v);
        ce_i <= 1'b0;
        meas_valid_i <= 1'b1;
        meas_chan_i <= c;
        meas_data_i <= v;
        @(posedge clk_i);
        meas_valid_i <= 1'b0;
        repeat (2) @(posedge clk_i);
        chk_alert("frozen low alert", lo_q, aux_low_alert_o);
        chk_alert("frozen high alert", hi_q, aux_high_alert_o);
        ce_i <= 1'b1;
        @(posedge clk_i);
    endtask
    task load_levels(input c);
        reg [13:0] a, b;
        begin
            abs_q = c ? 4'h5 : 4'($urandom);
            wb_op(1'b1, 10'h100, {28'h0, abs_q}, 4'hf);
            wb_op(1'b0, 10'h100, 32'h0, 4'hf);
            chk_word("reference select", {28'h0, abs_q}, q);
            for (j = 0; j < 3; j = j + 1) begin
                a = c ? ((j == 1) ? 14'h3fff : 14'h0) : 14'($urandom);
                b = c ? a : 14'($urandom);
                if (a > b) {a, b} = {b, a};
                wr(2 * j + 1, {16'h0, (j == 1) ? b : a, 2'b00}, 4'h3);
                wr(2 * j, {16'h0, (j == 1) ? a : b, 2'b00}, 4'h3);
            end
        end
    endtask
    task complete_run;
        $display("checks %0d errors %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    initial begin
        #500000;
        error_cnt = error_cnt + 1;
        complete_run;
    end
    initial begin
        {rst_i, ce_i, wb_cyc_i, wb_stb_i, wb_we_i, meas_valid_i} = 6'b110000;
        {wb_adr_i, wb_sel_i, wb_dat_i, meas_chan_i, meas_data_i} = 0;
        {abs_q, lo_q, hi_q} = 0;
        for (i = 0; i < 6; i = i + 1) m[i] = (i == 2 || i == 3) ? 16'hfffc : 16'h0;
        i = $urandom(69536);
        repeat (20) @(posedge clk_i);
        rst_i <= 1'b0;
        for (k = 0; k < 66; k = k + 1) begin
            i = $urandom % 6;
            if (k >= 6) wr(i, $urandom, 4'($urandom));
            wb_op(1'b0, {8'h32 + i[7:0], 2'b00}, 32'h0, 4'h3);
            chk_word("readback", {16'h0, m[i]}, q);
        end
        wb_op(1'b0, 10'h3fc, 32'h0, 4'hf);
        chk_word("unmapped error", 32'h1, {31'h0, e});
        for (k = 0; k < 400; k = k + 1) begin
            if (k % 25 == 0) load_levels(k == 0);
            t = $urandom % 10;
            j = $urandom % 6;
            r = (t < 6) ? m[j][15:2] + 14'(t % 3) - 14'h1 : 14'($urandom);
            if (t > 7) r = (t == 8) ? 14'h0 : 14'h3fff;
            if (k % 25 == 12) hold_meas(2'($urandom), r);
            meas(2'($urandom), r);
        end
        complete_run;
    end
endmodule

/* File: aux_thr_defs.vh */
// register map, field layout, reset values and sizes for the auxiliary alert threshold block
`ifndef AUX_THR_DEFS_VH
`define AUX_THR_DEFS_VH

// register indices; byte address is four times the index
`define IDX_RATIO_LOW_CLR 8'h32
`define IDX_RATIO_LOW_SET 8'h33
`define IDX_ABS_HIGH_CLR 8'h34
`define IDX_ABS_HIGH_SET 8'h35
`define IDX_ABS_LOW_CLR 8'h36
`define IDX_ABS_LOW_SET 8'h37
`define IDX_CTRL 8'h40
`define IDX_STATUS 8'h41

// threshold field inside a 16-bit word
`define THR_MSB 15
`define THR_LSB 2
`define THR_W 14
`define NUM_AUX 4

// reset values of the 14-bit threshold fields and of the 32-bit control register
`define RST_RATIO_LOW_CLR 14'h0000
`define RST_RATIO_LOW_SET 14'h0000
`define RST_ABS_HIGH_CLR 14'h3fff
`define RST_ABS_HIGH_SET 14'h3fff
`define RST_ABS_LOW_CLR 14'h0000
`define RST_ABS_LOW_SET 14'h0000
`define RST_CTRL 32'h0000_0000

// disable codes of the 14-bit fields
`define THR_OFF_HIGH 14'h3fff
`define THR_OFF_LOW 14'h0000

// status layout: [3:0] low alerts, [7:4] high alerts
`define ST_LOW_LSB 0
`define ST_HIGH_LSB 4

`endif
